//--- pkg/gcf_pkg.sv
package gcf_pkg;
   localparam int DATA_W = 16;
   localparam int CMD_W = 32;
   localparam int FIFO_DEPTH = 16;
   localparam int CNT_W = 5;
   localparam int ADDR_W = 3;
   // register offsets
   localparam logic [2:0] ADDR_CMD_LO = 3'h0;
   localparam logic [2:0] ADDR_CMD_HI = 3'h1;
   localparam logic [2:0] ADDR_CTRL = 3'h2;
   localparam logic [2:0] ADDR_IRQ_STAT = 3'h3;
   localparam logic [2:0] ADDR_IRQ_EN = 3'h4;
   localparam logic [2:0] ADDR_IRQ_CLR = 3'h5;
   // control field positions
   localparam int CTRL_EN_BIT = 15;
   localparam int CTRL_SIDL_BIT = 13;
   localparam int CTRL_WMK_LSB = 8;
   localparam int CTRL_BPP_LSB = 5;
   localparam int CTRL_CNT_LSB = 0;
   localparam logic [15:0] CTRL_RW_MASK = 16'hBFE0;
   localparam logic [15:0] RESET_VAL = 16'h0000;
   // status bits
   localparam int IRQ_LOWLVL_BIT = 0;
   localparam int IRQ_OVERFLOW_BIT = 1;
   localparam int IRQ_W = 2;
   // colour depth codes
   typedef enum logic [2:0] {
      GCF_BPP1 = 3'h0,
      GCF_BPP2 = 3'h1,
      GCF_BPP4 = 3'h2,
      GCF_BPP8 = 3'h3,
      GCF_BPP16 = 3'h4
   } gcf_bpp_e;
   typedef struct packed {
      logic [2:0] addr;
      logic [15:0] wdata;
      logic [1:0] byteEn;
      logic wr;
      logic rd;
   } gcf_bus_s;
endpackage

//--- core/gcf_cmd_fifo.sv
`timescale 1ns/10ps
module gcf_cmd_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16,
   parameter int CW = 5
) (
   // system
   input wire logic clk_sys,
   input wire logic rst_b,
   // fill side
   input wire logic pushValid,
   input wire logic [WIDTH-1:0] pushData,
   output logic pushReady,
   // drain side
   output logic popValid,
   output logic [WIDTH-1:0] popData,
   input wire logic popReady,
   // status
   output logic [CW-1:0] count
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wrPtr_q;
   logic [PW-1:0] rdPtr_q;
   logic [CW-1:0] count_q;
   wire doPush = pushValid && pushReady;
   wire doPop = popValid && popReady;
   assign pushReady = (count_q != CW'(DEPTH));
   assign popValid = (count_q != '0);
   assign popData = mem_q[rdPtr_q];
   assign count = count_q;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         if (doPush) wrPtr_q <= wrPtr_q + PW'(1);
         if (doPop) rdPtr_q <= rdPtr_q + PW'(1);
         count_q <= count_q + CW'(doPush) - CW'(doPop);
      end
   end
   genvar i;
   for (i = 0; i < DEPTH; i++) begin : g_ent
      always_ff @(posedge clk_sys or negedge rst_b) begin
         if (!rst_b) mem_q[i] <= '0;
         else if (doPush && wrPtr_q == PW'(i)) mem_q[i] <= pushData;
      end
   end
endmodule // gcf_cmd_fifo

//--- core/gcf_top.sv
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module gcf_top (
   // system
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic cpuIdle,
   // register port
   input wire logic [2:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic [1:0] regByteEn,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdata,
   // command stream to engines
   output logic cmdValid,
   output logic [31:0] cmdData,
   input wire logic cmdTake,
   // control outputs
   output logic moduleRun,
   output logic [2:0] colourDepth,
   output logic fifoLowLevelFlag,
   output logic irq
);
   gcf_pkg::gcf_bus_s bus;
   logic [15:0] cmdLo_q;
   logic [15:0] cmdHi_q;
   logic [15:0] ctrl_q;
   logic [gcf_pkg::IRQ_W-1:0] irqStat_q;
   logic [gcf_pkg::IRQ_W-1:0] irqEn_q;
   logic [15:0] regRdata_q;
   logic cmdValid_q;
   logic [31:0] cmdData_q;
   logic run_q;
   logic irq_q;
   logic [4:0] prevCnt_q;
   logic [4:0] cnt;
   logic pushReady;
   logic popValid;
   logic [31:0] popData;
   assign bus = '{addr: regAddr, wdata: regWdata, byteEn: regByteEn,
                  wr: regWr, rd: regRd};
   // decode
   wire wrLo = bus.wr && bus.addr == gcf_pkg::ADDR_CMD_LO;
   wire wrHi = bus.wr && bus.addr == gcf_pkg::ADDR_CMD_HI;
   wire wrCtrl = bus.wr && bus.addr == gcf_pkg::ADDR_CTRL;
   wire wrEn = bus.wr && bus.addr == gcf_pkg::ADDR_IRQ_EN;
   wire wrClr = bus.wr && bus.addr == gcf_pkg::ADDR_IRQ_CLR;
   wire [15:0] laneMask = {{8{bus.byteEn[1]}}, {8{bus.byteEn[0]}}};
   // a push fires on any ADDR_CMD_HI write touching the high byte lane
   wire pushCmd = wrHi && bus.byteEn[1];
   wire [15:0] hiNext = (cmdHi_q & ~laneMask) | (bus.wdata & laneMask);
   wire [31:0] cmdWord = {hiNext, cmdLo_q};
   // control honours byte lanes like the command halves; count bits stay 0
   wire [15:0] ctrlNext = ((ctrl_q & ~laneMask) | (bus.wdata & laneMask))
                          & gcf_pkg::CTRL_RW_MASK;
   wire [4:0] wmk = ctrl_q[gcf_pkg::CTRL_WMK_LSB +: 5];
   // crossing N to N-1 only; zero watermark can never match
   wire lowHit = (wmk != 5'h00) && (prevCnt_q == wmk)
                 && (cnt == wmk - 5'h01);
   wire dropHit = pushCmd && !pushReady;
   wire [gcf_pkg::IRQ_W-1:0] evt = {dropHit, lowHit};
   wire [gcf_pkg::IRQ_W-1:0] clrMask = wrClr ? bus.wdata[1:0] : 2'h0;
   // new commands are loaded only while the module runs; a held one stays valid after a take until the module runs again
   wire runNow = ctrl_q[gcf_pkg::CTRL_EN_BIT]
                 && !(ctrl_q[gcf_pkg::CTRL_SIDL_BIT] && cpuIdle);
   wire take = cmdTake && cmdValid_q;
   wire [15:0] ctrlRd = (ctrl_q & gcf_pkg::CTRL_RW_MASK)
                        | {11'h000, cnt};
   logic [15:0] rdMux;
   always_comb begin
      unique case (bus.addr)
         gcf_pkg::ADDR_CMD_LO: rdMux = cmdLo_q;
         gcf_pkg::ADDR_CMD_HI: rdMux = cmdHi_q;
         gcf_pkg::ADDR_CTRL: rdMux = ctrlRd;
         gcf_pkg::ADDR_IRQ_STAT: rdMux = {14'h0000, irqStat_q};
         gcf_pkg::ADDR_IRQ_EN: rdMux = {14'h0000, irqEn_q};
         default: rdMux = 16'h0000;
      endcase
   end
   gcf_cmd_fifo #(
      .WIDTH(gcf_pkg::CMD_W),
      .DEPTH(gcf_pkg::FIFO_DEPTH),
      .CW(gcf_pkg::CNT_W)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .pushValid(pushCmd),
      .pushData(cmdWord),
      .pushReady(pushReady),
      .popValid(popValid),
      .popData(popData),
      .popReady(run_q && (!cmdValid_q || take)),
      .count(cnt)
   );
   // registers survive a module disable
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cmdLo_q <= gcf_pkg::RESET_VAL;
         cmdHi_q <= gcf_pkg::RESET_VAL;
         ctrl_q <= gcf_pkg::RESET_VAL;
      end else begin
         if (wrLo) cmdLo_q <= (cmdLo_q & ~laneMask)
                              | (bus.wdata & laneMask);
         if (wrHi) cmdHi_q <= hiNext;
         if (wrCtrl) ctrl_q <= ctrlNext;
      end
   end
   // set wins over clear
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irqStat_q <= '0;
         irqEn_q <= '0;
         irq_q <= 1'b0;
         prevCnt_q <= '0;
      end else begin
         irqStat_q <= (irqStat_q & ~clrMask) | evt;
         if (wrEn && bus.byteEn[0]) irqEn_q <= bus.wdata[1:0];
         irq_q <= |(((irqStat_q & ~clrMask) | evt) & irqEn_q);
         prevCnt_q <= cnt;
      end
   end
   // output stage: one-entry holding register toward engines
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cmdValid_q <= 1'b0;
         cmdData_q <= '0;
         run_q <= 1'b0;
         regRdata_q <= '0;
      end else begin
         run_q <= runNow;
         regRdata_q <= bus.rd ? rdMux : 16'h0000;
         if (run_q && (!cmdValid_q || take)) begin
            cmdValid_q <= popValid;
            if (popValid) cmdData_q <= popData;
         end
      end
   end
   assign regRdata = regRdata_q;
   assign cmdValid = cmdValid_q;
   assign cmdData = cmdData_q;
   assign moduleRun = run_q;
   assign colourDepth = ctrl_q[gcf_pkg::CTRL_BPP_LSB +: 3];
   assign fifoLowLevelFlag = irqStat_q[gcf_pkg::IRQ_LOWLVL_BIT];
   assign irq = irq_q;
endmodule // gcf_top

//--- tb/gcf_top_asserts.sv
`timescale 1ns/10ps
module gcf_top_asserts (
   // system
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic cpuIdle,
   // register port
   input wire logic [2:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic [1:0] regByteEn,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [15:0] regRdata,
   // command stream
   input wire logic cmdValid,
   input wire logic [31:0] cmdData,
   input wire logic cmdTake,
   // control outputs
   input wire logic moduleRun,
   input wire logic [2:0] colourDepth,
   input wire logic fifoLowLevelFlag,
   input wire logic irq
);
   // shadow copy, so field rules can be checked without internal probes
   logic [15:0] ctlQ;
   logic ienQ;
   wire ctlWr = regWr && regAddr == gcf_pkg::ADDR_CTRL;
   wire ienWr = regWr && regAddr == gcf_pkg::ADDR_IRQ_EN;
   wire clrLow = regWr && regAddr == gcf_pkg::ADDR_IRQ_CLR && regWdata[0];
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctlQ <= 16'h0000;
         ienQ <= 1'b0;
      end else begin
         if (ctlWr && regByteEn[1]) ctlQ[15:8] <= regWdata[15:8];
         if (ctlWr && regByteEn[0]) ctlQ[7:0] <= regWdata[7:0];
         if (ienWr && regByteEn[0]) ienQ <= regWdata[0];
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   ctrl_read_a: assert property (
      $past(regRd && regAddr == gcf_pkg::ADDR_CTRL) |->
      regRdata[15:5] == $past(ctlQ[15:5] & gcf_pkg::CTRL_RW_MASK[15:5]))
      else $error("control readback wrong");
   cmd_hold_a: assert property (
      cmdValid && !cmdTake |=> cmdValid && $stable(cmdData))
      else $error("command dropped before take");
   run_gate_a: assert property (
      moduleRun == $past(ctlQ[15] && !(ctlQ[13] && cpuIdle)))
      else $error("run state wrong");
   pop_run_a: assert property ($rose(cmdValid) |-> $past(moduleRun))
      else $error("command issued while stopped");
   depth_out_a: assert property (
      $changed(ctlQ[7:5]) |-> ##[0:1] colourDepth == ctlQ[7:5])
      else $error("colour depth not followed");
   flag_hold_a: assert property ($fell(fifoLowLevelFlag) |-> $past(clrLow))
      else $error("low-level flag lost");
   wmk_off_a: assert property (
      $rose(fifoLowLevelFlag) |-> $past(ctlQ[12:8]) != 5'h00)
      else $error("low-level flag with watermark off");
   low_irq_a: assert property (
      fifoLowLevelFlag && ienQ && !clrLow |=> irq)
      else $error("interrupt missing");
endmodule // gcf_top_asserts
bind gcf_top gcf_top_asserts i_gcf_top_asserts (.*);

//--- tb/gcf_top_tb.sv
`timescale 1ns/10ps
module gcf_top_tb;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic cpuIdle = 1'b0;
   logic [2:0] regAddr = 3'h0;
   logic [15:0] regWdata = 16'h0000;
   logic [1:0] regByteEn = 2'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic cmdTake = 1'b0;
   logic takeOn = 1'b0;
   logic rdPend = 1'b0;
   logic [15:0] regRdata, lo, hi;
   logic [31:0] cmdData;
   logic [2:0] colourDepth;
   logic cmdValid, moduleRun, fifoLowLevelFlag, irq;
   logic [15:0] rdQ[$];
   logic [31:0] cmdQ[$];
   integer seed = 32'hd2382a75;
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;
   always #20 clk_sys = ~clk_sys;
   gcf_top i_gcf_top (.clk_sys, .rst_b, .cpuIdle, .regAddr, .regWdata,
      .regByteEn, .regWr, .regRd, .regRdata, .cmdValid, .cmdData, .cmdTake,
      .moduleRun, .colourDepth, .fifoLowLevelFlag, .irq);
   task chk(input string what, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task close_out;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task wr(input logic [2:0] a, input logic [15:0] d, input logic [1:0] be);
      @(posedge clk_sys);
      regAddr <= a;
      regWdata <= d;
      regByteEn <= be;
      regWr <= 1'b1;
      regRd <= 1'b0;
   endtask
   task rd(input logic [2:0] a, input logic [15:0] e);
      @(posedge clk_sys);
      regAddr <= a;
      regWr <= 1'b0;
      regRd <= 1'b1;
      rdQ.push_back(e);
   endtask
   task idle(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         regWr <= 1'b0;
         regRd <= 1'b0;
      end
   endtask
   // a stuck engine path must not pass quietly
   task drain;
      idle(1);
      for (int n = 0; n < 1000 && cmdQ.size() > 0; n++) idle(1);
      chk("cmdLeft", cmdQ.size(), 32'h0);
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         close_out;
      end
   end
   // results are compared as they appear, oldest note first
   always @(posedge clk_sys) begin
      if (rdPend) chk("regRdata", regRdata, rdQ.pop_front());
      if (cmdValid && cmdTake) chk("cmdData", cmdData, cmdQ.pop_front());
      rdPend <= regRd;
      cmdTake <= takeOn && ($random(seed) & 1) != 0;
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      for (int b = 0; b < 5; b++) begin
         wr(gcf_pkg::ADDR_CTRL, 16'h4000 | 16'(b << 5), 2'h3);
         rd(gcf_pkg::ADDR_CTRL, 16'(b << 5));
      end
      wr(gcf_pkg::ADDR_CMD_LO, 16'h5A5A, 2'h3);
      rd(gcf_pkg::ADDR_CMD_LO, 16'h5A5A);
      rd(3'h7, 16'h0000);
      chk("colourDepth", colourDepth, 32'h4);
      rd(gcf_pkg::ADDR_CTRL, 16'h0080);
      $display("register test done");
      // fill while stopped in idle, one push beyond capacity
      cpuIdle <= 1'b1;
      wr(gcf_pkg::ADDR_CTRL, 16'hA500, 2'h3);
      for (int i = 0; i < 17; i++) begin
         lo = 16'($random(seed));
         hi = 16'($random(seed));
         wr(gcf_pkg::ADDR_CMD_LO, lo, 2'h3);
         wr(gcf_pkg::ADDR_CMD_HI, hi, 2'h1);
         wr(gcf_pkg::ADDR_CMD_HI, hi, i[0] ? 2'h3 : 2'h2);
         if (i < 16) cmdQ.push_back({hi, lo});
      end
      idle(1);
      rd(gcf_pkg::ADDR_CTRL, 16'hA510);
      wr(gcf_pkg::ADDR_IRQ_EN, 16'h0001, 2'h3);
      idle(1);
      cpuIdle <= 1'b0;
      takeOn <= 1'b1;
      drain;
      idle(3);
      chk("irq", irq, 32'h1);
      rd(gcf_pkg::ADDR_IRQ_STAT, 16'h0003);
      wr(gcf_pkg::ADDR_IRQ_CLR, 16'h0003, 2'h3);
      rd(gcf_pkg::ADDR_IRQ_STAT, 16'h0000);
      rd(gcf_pkg::ADDR_CTRL, 16'hA500);
      idle(3);
      chk("irq", irq, 32'h0);
      // watermark off: draining to empty must leave the flag alone
      wr(gcf_pkg::ADDR_CTRL, 16'h8000, 2'h3);
      for (int i = 0; i < 2; i++) begin
         lo = 16'($random(seed));
         hi = 16'($random(seed));
         wr(gcf_pkg::ADDR_CMD_LO, lo, 2'h3);
         wr(gcf_pkg::ADDR_CMD_HI, hi, 2'h3);
         cmdQ.push_back({hi, lo});
      end
      drain;
      idle(2);
      rd(gcf_pkg::ADDR_IRQ_STAT, 16'h0000);
      // watermark one: the last command leaving sets the flag
      wr(gcf_pkg::ADDR_CTRL, 16'h8100, 2'h3);
      wr(gcf_pkg::ADDR_CMD_HI, hi, 2'h3);
      cmdQ.push_back({hi, lo});
      drain;
      idle(2);
      rd(gcf_pkg::ADDR_IRQ_STAT, 16'h0001);
      idle(2);
      chk("irq", irq, 32'h1);
      chk("moduleRun", moduleRun, 32'h1);
      chk("colourDepth", colourDepth, 32'h0);
      $display("fifo test done");
      close_out;
   end
endmodule // gcf_top_tb
